// ### adc_conversion_controller.sv
// conversion controller: axi4-lite registers, triggers, sar sequencer
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_controller #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire  logic              MCLK_I,
  input  wire  logic              RSTN_I,
  input  wire  logic [ADDR_W-1:0] AWADDR_I,
  input  wire  logic              AWVALID_I,
  output logic                    AWREADY_O,
  input  wire  logic [31:0]       WDATA_I,
  input  wire  logic [3:0]        WSTRB_I,
  input  wire  logic              WVALID_I,
  output logic                    WREADY_O,
  output logic [1:0]              BRESP_O,
  output logic                    BVALID_O,
  input  wire  logic              BREADY_I,
  input  wire  logic [ADDR_W-1:0] ARADDR_I,
  input  wire  logic              ARVALID_I,
  output logic                    ARREADY_O,
  output logic [31:0]             RDATA_I_UNUSED_O,
  output logic [1:0]              RRESP_O,
  output logic                    RVALID_O,
  input  wire  logic              RREADY_I,
  input  wire  adc_ctrl_pkg::trig_in_t TRIG_I,
  input  wire  logic              PWM_CENTER_I,
  input  wire  logic              PWM_END_I,
  input  wire  logic              PWM_CENTER_ALIGNED_I,
  input  wire  logic              SAR_CMP_I,
  output logic [11:0]             SAR_DAC_O,
  output logic                    SAR_SAMPLE_O,
  output logic [3:0]              CHANNEL_O,
  output logic                    POWER_O,
  output logic [7:0]              DIG_DISABLE_O,
  output logic                    IRQ_O,
  output logic                    CMP_EVENT_O,
  output logic                    FAULT_BRAKE_O,
  output logic                    EXPANSION_RAM_WE_O,
  output logic [15:0]             EXPANSION_RAM_ADDR_O,
  output logic [15:0]             EXPANSION_RAM_WDATA_O
);
  import adc_ctrl_pkg::*;

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---- state
  cfg_t        cfg, next_cfg;
  conv_state_t state, next_state;
  logic        busy, next_busy;
  logic        done, next_done;
  logic        cmp_out, next_cmp_out;
  logic [11:0] result, next_result;
  logic [11:0] code, next_code;
  logic [3:0]  bit_idx, next_bit_idx;
  logic [8:0]  dly_cnt, next_dly_cnt;
  logic [2:0]  smp_cnt, next_smp_cnt;
  logic [2:0]  div_cnt;
  logic [7:0]  dma_idx, next_dma_idx;
  trig_in_t    trig_prev;
  logic        irq, next_irq;
  logic        evt, next_evt;
  logic        brake, next_brake;
  logic        xwe, next_xwe;
  logic [15:0] xaddr, next_xaddr;
  logic [15:0] xdata, next_xdata;
  logic        sample, next_sample;

  // ---- bus state
  logic              aw_hold, next_aw_hold;
  logic              w_hold, next_w_hold;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic [31:0]       wdata, next_wdata;
  logic [3:0]        wstrb, next_wstrb;
  logic              bvalid, next_bvalid;
  logic [1:0]        bresp, next_bresp;
  logic              rvalid, next_rvalid;
  logic [1:0]        rresp, next_rresp;
  logic [31:0]       rdata, next_rdata;
  logic              awready, wready, arready;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  function automatic logic known_off(input logic [7:0] a);
    return a <= OFF_DIG_DIS && a[1:0] == 2'h0;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case (a)
      OFF_CTRL0: v = {24'h0, done, busy, cfg.trig_src, cfg.chan};
      OFF_CTRL1: v = {24'h0, cfg.irq_en, 1'b0, cfg.clk_div,
                      cfg.trig_type, cfg.hw_trig_en, cfg.power_on};
      OFF_CTRL2: v = {24'h0, cfg.brake_en, cfg.polarity, cfg.cmp_en,
                      cmp_out, 4'h0};
      OFF_RES_HIGH: v = {24'h0, result[11:4]};
      OFF_RES_LOW:  v = {28'h0, result[3:0]};
      OFF_THR_HIGH: v = {24'h0, cfg.threshold[11:4]};
      OFF_THR_LOW:  v = {28'h0, cfg.threshold[3:0]};
      OFF_DELAY:    v = {23'h0, cfg.delay};
      OFF_DMA_CTRL: v = {31'h0, cfg.dma_en};
      OFF_DMA_BASE: v = {16'h0, cfg.dma_base};
      OFF_DMA_CNT:  v = {24'h0, cfg.dma_count};
      OFF_DIG_DIS:  v = {24'h0, cfg.dig_disable};
      default:      v = 32'h0;
    endcase
    return v;
  endfunction

  // ---- axi4-lite slave
  logic        wr_go;
  logic [7:0]  wa8;
  logic [31:0] wmerged;
  assign wr_go   = aw_hold && w_hold && !bvalid;
  assign wa8     = 8'(waddr);
  // process form so register state read inside reg_read wakes it too
  always_comb wmerged = strb_merge(reg_read(wa8), wdata, wstrb);

  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_waddr   = waddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (AWVALID_I && awready) begin
      next_aw_hold = 1'b1;
      next_waddr   = AWADDR_I;
    end
    if (WVALID_I && wready) begin
      next_w_hold = 1'b1;
      next_wdata  = WDATA_I;
      next_wstrb  = WSTRB_I;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = known_off(wa8) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && BREADY_I) begin
      next_bvalid = 1'b0;
    end
    if (ARVALID_I && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = reg_read(8'(ARADDR_I));
      next_rresp  = known_off(8'(ARADDR_I)) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && RREADY_I) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      waddr   <= '0;
      wdata   <= 32'h0;
      wstrb   <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      waddr   <= next_waddr;
      wdata   <= next_wdata;
      wstrb   <= next_wstrb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      awready <= !next_aw_hold && !next_bvalid;
      wready  <= !next_w_hold && !next_bvalid;
      arready <= !next_rvalid;
    end
  end

  // ---- triggers
  function automatic logic src_level(input trig_in_t t,
                                     input logic [1:0] s);
    logic l;
    l = 1'b0;
    unique case (s)
      SRC_PWM0: l = t.pwm_ch[0];
      SRC_PWM2: l = t.pwm_ch[1];
      SRC_PWM4: l = t.pwm_ch[2];
      SRC_PIN:  l = t.ext_pin;
    endcase
    return l;
  endfunction

  logic cur_l, prev_l, trig_hit;
  assign cur_l  = src_level(TRIG_I, cfg.trig_src);
  assign prev_l = src_level(trig_prev, cfg.trig_src);
  always_comb begin
    trig_hit = 1'b0;
    unique case (cfg.trig_type)
      TYP_FALL: trig_hit = prev_l && !cur_l;
      TYP_RISE: trig_hit = !prev_l && cur_l;
      // period points exist only for pwm sources in centre-aligned mode
      TYP_CTR:  trig_hit = PWM_CENTER_I && PWM_CENTER_ALIGNED_I &&
                           cfg.trig_src != SRC_PIN;
      TYP_END:  trig_hit = PWM_END_I && PWM_CENTER_ALIGNED_I &&
                           cfg.trig_src != SRC_PIN;
    endcase
  end

  // ---- register writes and software events
  logic sw_start, done_clr, hw_start, tick;
  assign sw_start = wr_go && wa8 == OFF_CTRL0 && wmerged[C0_BUSY];
  assign done_clr = wr_go && wa8 == OFF_CTRL0 && !wmerged[C0_DONE];
  assign hw_start = cfg.hw_trig_en && trig_hit;
  // adc clock is the system clock divided by 1, 2, 4 or 8
  assign tick = (div_cnt & 3'((4'h1 << cfg.clk_div) - 4'h1)) ==
                3'((4'h1 << cfg.clk_div) - 4'h1);

  always_comb begin
    next_cfg = cfg;
    if (wr_go) begin
      unique case (wa8)
        OFF_CTRL0: begin
          next_cfg.trig_src = wmerged[C0_SRC+:2];
          next_cfg.chan     = wmerged[3:0];
        end
        OFF_CTRL1: begin
          next_cfg.irq_en     = wmerged[C1_IE];
          next_cfg.clk_div    = wmerged[C1_DIV+:2];
          next_cfg.trig_type  = wmerged[C1_TYPE+:2];
          next_cfg.hw_trig_en = wmerged[C1_HWEN];
          next_cfg.power_on   = wmerged[C1_PWR];
        end
        OFF_CTRL2: begin
          next_cfg.brake_en = wmerged[C2_BRK];
          next_cfg.polarity = wmerged[C2_POL];
          next_cfg.cmp_en   = wmerged[C2_CMPEN];
        end
        OFF_THR_HIGH: next_cfg.threshold[11:4] = wmerged[7:0];
        OFF_THR_LOW:  next_cfg.threshold[3:0]  = wmerged[3:0];
        OFF_DELAY:    next_cfg.delay       = wmerged[8:0];
        OFF_DMA_CTRL: next_cfg.dma_en      = wmerged[0];
        OFF_DMA_BASE: next_cfg.dma_base    = wmerged[15:0];
        OFF_DMA_CNT:  next_cfg.dma_count   = wmerged[7:0];
        OFF_DIG_DIS:  next_cfg.dig_disable = wmerged[7:0];
        default:      next_cfg = cfg;
      endcase
    end
  end

  // ---- conversion sequencer
  logic fin_match, fin_more, fin_set;
  always_comb begin
    fin_match = cfg.polarity ? (result < cfg.threshold)
                             : (result >= cfg.threshold);
    fin_more  = cfg.dma_en && (dma_idx + 8'h1) < cfg.dma_count;
    fin_set   = 1'b0;
    next_state   = state;
    next_busy    = busy;
    next_result  = result;
    next_code    = code;
    next_bit_idx = bit_idx;
    next_dly_cnt = dly_cnt;
    next_smp_cnt = smp_cnt;
    next_dma_idx = dma_idx;
    next_cmp_out = cmp_out;
    next_evt     = 1'b0;
    next_brake   = 1'b0;
    next_xwe     = 1'b0;
    next_xaddr   = xaddr;
    next_xdata   = xdata;
    unique case (state)
      ST_IDLE: begin
        // busy or unread done drops the request silently
        if ((sw_start || hw_start) && !busy && !done) begin
          next_busy    = 1'b1;
          next_dma_idx = 8'h0;
          next_smp_cnt = 3'h0;
          if (!sw_start && cfg.delay != 9'h0) begin
            next_dly_cnt = cfg.delay;
            next_state   = ST_DELAY;
          end else begin
            next_state = ST_SAMPLE;
          end
        end
      end
      ST_DELAY: begin
        next_dly_cnt = dly_cnt - 9'h1;
        if (dly_cnt == 9'h1) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          next_smp_cnt = smp_cnt + 3'h1;
          if (smp_cnt == 3'(SAMPLE_TICKS - 1)) begin
            next_code    = 12'h800;
            next_bit_idx = 4'(RES_BITS - 1);
            next_state   = ST_CONVERT;
          end
        end
      end
      ST_CONVERT: begin
        // binary search, full reference settles at all ones
        if (tick) begin
          if (!SAR_CMP_I) begin
            next_code[bit_idx] = 1'b0;
          end
          if (bit_idx == 4'h0) begin
            next_result = SAR_CMP_I ? code : (code & 12'hFFE);
            next_state  = ST_FINISH;
          end else begin
            next_code[bit_idx-4'h1] = 1'b1;
            next_bit_idx = bit_idx - 4'h1;
          end
        end
      end
      ST_FINISH: begin
        if (cfg.cmp_en) begin
          next_cmp_out = fin_match;
          if (fin_match && cfg.brake_en) begin
            next_evt   = 1'b1;
            next_brake = 1'b1;
          end
        end
        if (cfg.dma_en) begin
          next_xwe     = 1'b1;
          next_xaddr   = cfg.dma_base + {8'h0, dma_idx};
          next_xdata   = {4'h0, result};
          next_dma_idx = dma_idx + 8'h1;
        end
        // keep converting until a match (when compare is on) and until dma done
        if ((cfg.cmp_en && !fin_match) || fin_more) begin
          next_smp_cnt = 3'h0;
          next_state   = ST_SAMPLE;
        end else begin
          fin_set    = 1'b1;
          next_busy  = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_done   = fin_set || (done && !done_clr);
    next_irq    = next_done && cfg.irq_en;
    next_sample = next_state == ST_SAMPLE;
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= CFG_RESET;
      state     <= ST_IDLE;
      busy      <= 1'b0;
      done      <= 1'b0;
      cmp_out   <= 1'b0;
      result    <= 12'h000;
      code      <= 12'h000;
      bit_idx   <= 4'h0;
      dly_cnt   <= 9'h000;
      smp_cnt   <= 3'h0;
      div_cnt   <= 3'h0;
      dma_idx   <= 8'h00;
      trig_prev <= '0;
      irq       <= 1'b0;
      evt       <= 1'b0;
      brake     <= 1'b0;
      xwe       <= 1'b0;
      xaddr     <= 16'h0000;
      xdata     <= 16'h0000;
      sample    <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      state     <= next_state;
      busy      <= next_busy;
      done      <= next_done;
      cmp_out   <= next_cmp_out;
      result    <= next_result;
      code      <= next_code;
      bit_idx   <= next_bit_idx;
      dly_cnt   <= next_dly_cnt;
      smp_cnt   <= next_smp_cnt;
      div_cnt   <= div_cnt + 3'h1;
      dma_idx   <= next_dma_idx;
      trig_prev <= TRIG_I;
      irq       <= next_irq;
      evt       <= next_evt;
      brake     <= next_brake;
      xwe       <= next_xwe;
      xaddr     <= next_xaddr;
      xdata     <= next_xdata;
      sample    <= next_sample;
    end
  end

  assign AWREADY_O        = awready;
  assign WREADY_O         = wready;
  assign BVALID_O         = bvalid;
  assign BRESP_O          = bresp;
  assign ARREADY_O        = arready;
  assign RVALID_O         = rvalid;
  assign RRESP_O          = rresp;
  assign RDATA_I_UNUSED_O = rdata;
  assign SAR_DAC_O        = code;
  assign SAR_SAMPLE_O     = sample;
  assign CHANNEL_O        = cfg.chan;
  assign POWER_O          = cfg.power_on;
  assign DIG_DISABLE_O    = cfg.dig_disable;
  assign IRQ_O            = irq;
  assign CMP_EVENT_O      = evt;
  assign FAULT_BRAKE_O    = brake;
  assign EXPANSION_RAM_WE_O        = xwe;
  assign EXPANSION_RAM_ADDR_O      = xaddr;
  assign EXPANSION_RAM_WDATA_O     = xdata;
endmodule
`default_nettype wire

// ### adc_conversion_controller_bench.sv
// testbench: bus tasks, sar partner and scenario tasks
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_controller_bench;
  import adc_ctrl_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0;
  logic        rready = 1'h0, pctr = 1'h0, pend = 1'h0, samp_q = 1'h0;
  logic        awrdy, wrdy, bv, arrdy, rv, cmp, samp, irq, brk, xwe, pwr, evt;
  logic        aligned = 1'h1;
  logic [7:0]  dig;
  logic [1:0]  bresp, rresp, rsp;
  logic [11:0] level = 12'h000, dac;
  logic [3:0]  chan;
  logic [15:0] xaddr, xdata, xa, xd;
  trig_in_t    trig = '0;
  int          mismatches = 0, checked = 0;
  int          nsamp = 0, nbrk = 0, nxw = 0, lat, lat0, nevt = 0;
  always #50 clk = ~clk;
  adc_conversion_controller i_adc_conversion_controller (
    .MCLK_I(clk), .RSTN_I(rstn), .AWADDR_I(awaddr), .AWVALID_I(awv),
    .AWREADY_O(awrdy), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wv),
    .WREADY_O(wrdy), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arrdy),
    .RDATA_I_UNUSED_O(rdata), .RRESP_O(rresp), .RVALID_O(rv),
    .RREADY_I(rready), .TRIG_I(trig), .PWM_CENTER_I(pctr),
    .PWM_END_I(pend), .PWM_CENTER_ALIGNED_I(aligned), .SAR_CMP_I(cmp),
    .SAR_DAC_O(dac), .SAR_SAMPLE_O(samp), .CHANNEL_O(chan), .POWER_O(pwr),
    .DIG_DISABLE_O(dig), .IRQ_O(irq), .CMP_EVENT_O(evt), .FAULT_BRAKE_O(brk),
    .EXPANSION_RAM_WE_O(xwe), .EXPANSION_RAM_ADDR_O(xaddr), .EXPANSION_RAM_WDATA_O(xdata));
  adc_sar_partner i_adc_sar_partner (.level_i(level), .chan_i(chan),
    .dac_i(dac), .cmp_o(cmp));
  // counts sample phases, brakes and stores seen at the ports
  always @(posedge clk) begin
    samp_q <= samp;
    if (samp && !samp_q) nsamp++;
    if (brk) nbrk++;
    if (evt) nevt++;
    if (xwe && nxw == 0) xa = xaddr;
    if (xwe) xd = xdata;
    if (xwe) nxw++;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      mismatches++;
      $display("MISMATCH wait expected answer seen timeout");
      close_out();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      n++;
    end while (!bv && n < 300);
    rsp = bresp;
    bready <= 1'h0;
    tmo(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'h0;
      n++;
    end while (!rv && n < 300);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
    tmo(n);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rdr(OFF_CTRL0);
      n++;
    end while (rd[C0_DONE] !== 1'h1 && n < 300);
    tmo(n);
  endtask
  task automatic hw_one(input logic [1:0] s, t, input logic v);
    int n;
    wr(OFF_CTRL0, {26'h0, s, 4'h0});
    wr(OFF_CTRL1, {28'h0, t, 2'h3});
    @(posedge clk);
    if (t == TYP_CTR) pctr <= 1'h1;
    else if (t == TYP_END) pend <= 1'h1;
    else if (s == SRC_PIN) trig.ext_pin <= v;
    else trig.pwm_ch[s] <= v;
    n = 0;
    do begin
      @(posedge clk);
      pctr <= 1'h0;
      pend <= 1'h0;
      n++;
    end while (!samp && n < 300);
    lat = n;
    tmo(n);
    rchk("busy", OFF_CTRL0, {24'h0, 2'h1, s, 4'h0});
    wait_done();
    wr(OFF_CTRL0, {26'h0, s, 4'h0});
  endtask
  task automatic t_sw;
    int n;
    wr(OFF_CTRL1, 32'h81);
    chk("power", 32'h1, {31'h0, pwr});
    level <= 12'h5A3;
    wr(OFF_CTRL0, 32'h43);
    wait_done();
    chk("ctrl0", 32'h83, rd);
    chk("channel", 32'h3, {28'h0, chan});
    rchk("res_high", OFF_RES_HIGH, 32'h6A);
    rchk("res_low", OFF_RES_LOW, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_CTRL1, 32'h01);
    @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFF_CTRL1, 32'h81);
    wr(OFF_CTRL0, 32'h33);
    n = nsamp;
    trig.ext_pin <= 1'h1;
    repeat (3) @(posedge clk);
    trig.ext_pin <= 1'h0;
    repeat (30) @(posedge clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    chk("hw_off", n, nsamp);
    wr(8'h30, 32'hFF);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test sw done");
  endtask
  task automatic t_busy;
    int n;
    n = nsamp;
    level <= 12'hFFF;
    wr(OFF_CTRL0, 32'h40);
    rchk("res_held", OFF_RES_HIGH, 32'h6A);
    wr(OFF_CTRL0, 32'h40);
    wait_done();
    wr(OFF_CTRL0, 32'hC0);
    repeat (30) @(posedge clk);
    chk("starts", n + 1, nsamp);
    rchk("res_high", OFF_RES_HIGH, 32'hFF);
    rchk("res_low", OFF_RES_LOW, 32'hF);
    wr(OFF_CTRL0, 32'h00);
    $display("test busy done");
  endtask
  task automatic t_hw;
    int n;
    // source changes are ordered so no stray edge reaches the selector
    trig.ext_pin <= 1'h1;
    hw_one(SRC_PIN, TYP_FALL, 1'h0);
    hw_one(SRC_PWM0, TYP_RISE, 1'h1);
    hw_one(SRC_PWM2, TYP_RISE, 1'h1);
    hw_one(SRC_PWM4, TYP_RISE, 1'h1);
    hw_one(SRC_PIN, TYP_RISE, 1'h1);
    lat0 = lat;
    hw_one(SRC_PWM0, TYP_CTR, 1'h0);
    hw_one(SRC_PWM0, TYP_END, 1'h0);
    // period point outside centre-aligned operation must not start
    aligned <= 1'h0;
    n = nsamp;
    @(posedge clk);
    pend <= 1'h1;
    @(posedge clk);
    pend <= 1'h0;
    repeat (5) @(posedge clk);
    chk("unaligned", n, nsamp);
    aligned <= 1'h1;
    trig.ext_pin <= 1'h0;
    wr(OFF_DELAY, 32'h28);
    hw_one(SRC_PIN, TYP_RISE, 1'h1);
    chk("delay", 32'h28, lat - lat0);
    wr(OFF_DELAY, 32'h0);
    wr(OFF_CTRL1, 32'h81);
    $display("test hw done");
  endtask
  task automatic t_cmp;
    int n;
    wr(OFF_THR_HIGH, 32'h40);
    wr(OFF_CTRL2, 32'hA0);
    level <= 12'h200;
    n = nsamp;
    wr(OFF_CTRL0, 32'h40);
    repeat (80) @(posedge clk);
    rchk("looping", OFF_CTRL0, 32'h40);
    chk("reruns", 32'h1, {31'h0, nsamp > n + 2});
    level <= 12'h600;
    wait_done();
    chk("brakes", 32'h1, nbrk);
    chk("events", 32'h1, nevt);
    rchk("ctrl2", OFF_CTRL2, 32'hB0);
    // inverted polarity: below threshold matches, brake left off
    wr(OFF_CTRL0, 32'h00);
    wr(OFF_CTRL2, 32'h60);
    level <= 12'h200;
    wr(OFF_CTRL0, 32'h40);
    wait_done();
    rchk("ctrl2_inv", OFF_CTRL2, 32'h70);
    chk("brakes_off", 32'h1, nbrk);
    wr(OFF_CTRL2, 32'h00);
    wr(OFF_CTRL0, 32'h00);
    $display("test cmp done");
  endtask
  task automatic t_dma;
    logic [7:0] hi;
    // slowest adc clock, band-gap input
    wr(OFF_CTRL1, 32'hB1);
    wr(OFF_DIG_DIS, 32'h5A);
    chk("dig_disable", 32'h5A, {24'h0, dig});
    wr(OFF_DMA_BASE, 32'h100);
    wr(OFF_DMA_CNT, 32'h3);
    wr(OFF_DMA_CTRL, 32'h1);
    level <= 12'h123;
    wr(OFF_CTRL0, 32'h48);
    wait_done();
    chk("channel_bg", {28'h0, CH_BANDGAP}, {28'h0, chan});
    chk("expansion_ram_writes", 32'h3, nxw);
    chk("expansion_ram_addr", 32'h100, {16'h0, xa});
    chk("expansion_ram_data", 32'h923, {16'h0, xd});
    rdr(OFF_RES_HIGH);
    hi = rd[7:0];
    rdr(OFF_RES_LOW);
    chk("joined", 32'h923, {20'h0, hi, rd[3:0]});
    $display("test dma done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    t_sw();
    t_busy();
    t_hw();
    t_cmp();
    t_dma();
    close_out();
  end
endmodule
`default_nettype wire

// ### adc_ctrl_monitor.sv
// port assertions for the conversion controller
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor (
  input wire logic        MCLK_I,
  input wire logic        RSTN_I,
  input wire logic        AWREADY_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  input wire logic [31:0] RDATA_I_UNUSED_O,
  input wire logic        SAR_SAMPLE_O,
  input wire logic        IRQ_O,
  input wire logic        CMP_EVENT_O,
  input wire logic        FAULT_BRAKE_O,
  input wire logic        EXPANSION_RAM_WE_O,
  input wire logic [15:0] EXPANSION_RAM_WDATA_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  AST_B_HOLD:
    assert property (BVALID_O && !BREADY_I |=> BVALID_O)
      else $error("write response dropped");
  AST_B_BLOCKS_AW:
    assert property (BVALID_O |-> !AWREADY_O)
      else $error("address taken with response pending");
  AST_R_HOLD:
    assert property (RVALID_O && !RREADY_I |=> RVALID_O
      && $stable(RDATA_I_UNUSED_O)) else $error("read data unstable");
  AST_SAMPLE_LEN:
    assert property ($rose(SAR_SAMPLE_O) |-> SAR_SAMPLE_O [*4])
      else $error("sample phase too short");
  AST_DONE_IDLE:
    assert property (IRQ_O |-> !SAR_SAMPLE_O)
      else $error("sampling while done");
  AST_X12:
    assert property (EXPANSION_RAM_WE_O |-> EXPANSION_RAM_WDATA_O[15:12] == 4'h0)
      else $error("stored word wider than result");
  AST_X_PULSE:
    assert property (EXPANSION_RAM_WE_O |=> !EXPANSION_RAM_WE_O)
      else $error("store strobe held");
  AST_BRAKE_EVT:
    assert property (FAULT_BRAKE_O |-> CMP_EVENT_O)
      else $error("brake without compare event");
endmodule
bind adc_conversion_controller adc_ctrl_monitor i_adc_ctrl_monitor (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .AWREADY_O(AWREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .RDATA_I_UNUSED_O(RDATA_I_UNUSED_O),
  .SAR_SAMPLE_O(SAR_SAMPLE_O), .IRQ_O(IRQ_O), .CMP_EVENT_O(CMP_EVENT_O),
  .FAULT_BRAKE_O(FAULT_BRAKE_O), .EXPANSION_RAM_WE_O(EXPANSION_RAM_WE_O),
  .EXPANSION_RAM_WDATA_O(EXPANSION_RAM_WDATA_O));
`default_nettype wire

// ### adc_ctrl_pkg.sv
// constants, field layout and types of the conversion controller
package adc_ctrl_pkg;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned RES_BITS    = 12;
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam logic [7:0] OFF_CTRL0    = 8'h00;
  localparam logic [7:0] OFF_CTRL1    = 8'h04;
  localparam logic [7:0] OFF_CTRL2    = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH = 8'h0C;
  localparam logic [7:0] OFF_RES_LOW  = 8'h10;
  localparam logic [7:0] OFF_THR_HIGH = 8'h14;
  localparam logic [7:0] OFF_THR_LOW  = 8'h18;
  localparam logic [7:0] OFF_DELAY    = 8'h1C;
  localparam logic [7:0] OFF_DMA_CTRL = 8'h20;
  localparam logic [7:0] OFF_DMA_BASE = 8'h24;
  localparam logic [7:0] OFF_DMA_CNT  = 8'h28;
  localparam logic [7:0] OFF_DIG_DIS  = 8'h2C;
  localparam int unsigned C0_DONE = 7;
  localparam int unsigned C0_BUSY = 6;
  localparam int unsigned C0_SRC  = 4;
  localparam int unsigned C1_IE   = 7;
  localparam int unsigned C1_DIV  = 4;
  localparam int unsigned C1_TYPE = 2;
  localparam int unsigned C1_HWEN = 1;
  localparam int unsigned C1_PWR  = 0;
  localparam int unsigned C2_BRK  = 7;
  localparam int unsigned C2_POL  = 6;
  localparam int unsigned C2_CMPEN = 5;
  localparam int unsigned C2_CMPO = 4;
  localparam logic [1:0] SRC_PWM0 = 2'h0;
  localparam logic [1:0] SRC_PWM2 = 2'h1;
  localparam logic [1:0] SRC_PWM4 = 2'h2;
  localparam logic [1:0] SRC_PIN  = 2'h3;
  localparam logic [1:0] TYP_FALL = 2'h0;
  localparam logic [1:0] TYP_RISE = 2'h1;
  localparam logic [1:0] TYP_CTR  = 2'h2;
  localparam logic [1:0] TYP_END  = 2'h3;
  localparam logic [3:0] CH_BANDGAP = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_DELAY   = 5'b00010,
    ST_SAMPLE  = 5'b00100,
    ST_CONVERT = 5'b01000,
    ST_FINISH  = 5'b10000
  } conv_state_t;
  typedef struct packed {
    logic        irq_en;
    logic [1:0]  clk_div;
    logic [1:0]  trig_type;
    logic        hw_trig_en;
    logic        power_on;
    logic        brake_en;
    logic        polarity;
    logic        cmp_en;
    logic [1:0]  trig_src;
    logic [3:0]  chan;
    logic [11:0] threshold;
    logic [8:0]  delay;
    logic        dma_en;
    logic [15:0] dma_base;
    logic [7:0]  dma_count;
    logic [7:0]  dig_disable;
  } cfg_t;
  typedef struct packed {
    logic [2:0] pwm_ch;
    logic       ext_pin;
  } trig_in_t;
  localparam cfg_t CFG_RESET = '0;
endpackage

// ### adc_sar_partner.sv
// sar analog core stand-in: per-channel level against the trial code
`timescale 1ns/1ps
`default_nettype none
module adc_sar_partner (
  input  wire logic [11:0] level_i,
  input  wire logic [3:0]  chan_i,
  input  wire logic [11:0] dac_i,
  output logic             cmp_o
);
  logic [11:0] vin;
  // channels differ so a wrong mux setting shows in the code
  assign vin = level_i ^ {chan_i, 8'h00};
  assign cmp_o = (vin >= dac_i);
endmodule
`default_nettype wire
